//--- inc/dac_cmd_params.svh
// Constants for the quad DAC write command decoder
`ifndef DAC_CMD_PARAMS_SVH
`define DAC_CMD_PARAMS_SVH

// ----------------------------------------------------------------
// Command byte fields
// ----------------------------------------------------------------
`define CT_HI 7
`define CT_LO 5
`define WF_HI 4
`define WF_LO 3
`define CS_HI 2
`define CS_LO 1
`define UPDATE_INHIBIT_BIT_POS 0
`define FAST_HI 7
`define FAST_LO 6
`define CT_FAST 2'h0
`define CT_MULTI 3'h2
`define CT_ADDR 3'h3
`define CT_VREF 3'h4
`define CT_PD 3'h5
`define CT_GAIN 3'h6
`define WF_MULTI 2'h0
`define WF_SEQ 2'h2
`define WF_SINGLE 2'h3

// ----------------------------------------------------------------
// Data byte fields
// ----------------------------------------------------------------
`define D_VREF 7
`define D_PD_HI 6
`define D_PD_LO 5
`define D_GAIN 4
`define D_CODE_HI 3
`define D_CODE_LO 0
`define ADDR_HI 4
`define ADDR_LO 2
`define LAST_CHAN 2'h3

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RST_ADDR 3'h0
`define RST_INHIBIT 4'hF
`define CLK_PERIOD_NS 10
`define NVM_PROG_TIME_NS 25000000
`define NVM_PROG_CYCLES (`NVM_PROG_TIME_NS / `CLK_PERIOD_NS)
`define NVM_CNT_W 22

`endif

//--- inc/dac_cmd_pkg.sv
// Types for the quad DAC write command decoder
`default_nettype none
package dac_cmd_pkg;

  typedef enum logic [3:0] {
    S_CMD = 4'h0,
    S_FAST_HI = 4'h1,
    S_FAST_LO = 4'h2,
    S_CH_HI = 4'h3,
    S_CH_LO = 4'h4,
    S_CFG_PD2 = 4'h5,
    S_ADDR_NEW = 4'h6,
    S_ADDR_CONF = 4'h7,
    S_SKIP = 4'h8
  } dec_state_t;

  typedef logic [3:0][11:0] code_arr_t;
  typedef logic [3:0][1:0] pd_arr_t;
  typedef logic [3:0][15:0] nvm_arr_t;

  typedef struct packed {
    dec_state_t st;
    logic [1:0] chan;
    logic [1:0] wfunc;
    logic update_inhibit_bit_cmd;
    logic [3:0] hi_cfg;
    logic [3:0] hi_code;
    logic [3:0] pend;
    logic [2:0] new_addr;
    logic addr_ok;
    logic addr_commit;
    logic prog_start;
    logic [2:0] load_strobe_n_sync;
    logic load_strobe_n_lo;
    code_arr_t in_code;
    logic [3:0] in_vref;
    logic [3:0] in_gain;
    pd_arr_t in_pd;
    logic [3:0] in_update_inhibit_bit;
    logic [3:0] in_fast;
    code_arr_t out_code;
    nvm_arr_t nvm;
    logic [2:0] addr;
    logic [2:0] nvm_addr;
    logic ready;
  } dec_regs_t;

endpackage : dac_cmd_pkg
`default_nettype wire

//--- core/nvm_prog_timer.sv
// Busy timer for nonvolatile programming
`timescale 1ns/1ps
`default_nettype none
`include "dac_cmd_params.svh"
module nvm_prog_timer #(
  parameter logic [`NVM_CNT_W-1:0] PROG_CYCLES = `NVM_CNT_W'(`NVM_PROG_CYCLES)
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  output logic busy_o
);

  logic [`NVM_CNT_W-1:0] cnt_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      busy_o <= 1'b0;
    end else if (start_i) begin
      cnt_q <= PROG_CYCLES;
      busy_o <= 1'b1;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
      busy_o <= (cnt_q != `NVM_CNT_W'(1));
    end
  end

endmodule : nvm_prog_timer
`default_nettype wire

//--- core/quad_dac_write_command_decoder.sv
// Write command decoder for a quad 12-bit DAC
// Overview of operation
// RULE1: Fast write loads A to D, no NVM
// RULE2: Fast write latches per channel, ignores function
// RULE3: Fast write output follows load strobe only
// RULE4: Multi-write stores one selected channel per group
// RULE5: Sequential write from selected channel to D
// RULE6: Sequential: registers per channel, NVM at end
// RULE7: Single write: register and NVM together
// RULE8: Address command stores new address, NVM too
// RULE9: Reference command sets all channels' reference bit
// RULE10: Gain command sets all channels' gain bit
// RULE11: Power-down command sets all channels' bits
// RULE12: Other writes update on strobe or inhibit low
// RULE13: NVM programming holds ready flag low
// RULE14: Unlisted codes do nothing
// RULE15: Command fields sit in the upper bits
`timescale 1ns/1ps
`default_nettype none
`include "dac_cmd_params.svh"
module quad_dac_write_command_decoder #(
  parameter logic [`NVM_CNT_W-1:0] NVM_PROG_CYCLES =
    `NVM_CNT_W'(`NVM_PROG_CYCLES)
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Received byte stream after the address byte
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic byte_ack_i,
  input wire logic [7:0] byte_i,
  // Load strobe pin
  input wire logic load_strobe_n_i,
  // Channel input registers
  output var dac_cmd_pkg::code_arr_t in_code_o,
  output logic [3:0] in_vref_o,
  output logic [3:0] in_gain_o,
  output var dac_cmd_pkg::pd_arr_t in_pd_o,
  output logic [3:0] update_inhibit_bit_o,
  // Analog output codes
  output var dac_cmd_pkg::code_arr_t out_code_o,
  // Nonvolatile image and status
  output var dac_cmd_pkg::nvm_arr_t nvm_o,
  output logic [2:0] bus_addr_o,
  output logic [2:0] nvm_addr_o,
  output logic nvm_ready_flag_o
);

  dac_cmd_pkg::dec_regs_t s_q;
  dac_cmd_pkg::dec_regs_t s_d;
  logic busy;

  // Channel image word as kept in the nonvolatile store
  function automatic logic [15:0] nvm_word(input dac_cmd_pkg::dec_regs_t r,
                                           input logic [1:0] c);
    nvm_word = {r.in_vref[c], r.in_pd[c], r.in_gain[c], r.in_code[c]};
  endfunction : nvm_word

  nvm_prog_timer #(
    .PROG_CYCLES(NVM_PROG_CYCLES)
  ) u_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(s_q.prog_start),
    .busy_o(busy)
  );

  always_comb begin
    logic take;
    logic [2:0] ct;
    take = 1'b0;
    ct = byte_i[`CT_HI:`CT_LO];
    s_d = s_q;
    s_d.prog_start = 1'b0;
    s_d.ready = ~busy & ~s_q.prog_start;
    // ----------------------------------------------------------------
    // Load strobe pin synchroniser
    // ----------------------------------------------------------------
    s_d.load_strobe_n_sync = {s_q.load_strobe_n_sync[1:0], ~load_strobe_n_i};
    if (s_q.load_strobe_n_sync[1] == s_q.load_strobe_n_sync[2]) begin
      s_d.load_strobe_n_lo = s_q.load_strobe_n_sync[2];
    end
    // ----------------------------------------------------------------
    // Byte decode; nothing is taken while programming
    // ----------------------------------------------------------------
    // Ready lags the start pulse by a cycle, so block that cycle too
    take = byte_ack_i & s_q.ready & ~s_q.prog_start; // see RULE13
    if (start_i) begin
      s_d.st = dac_cmd_pkg::S_CMD;
      s_d.addr_ok = 1'b0;
    end else if (take) begin
      unique case (s_q.st)
        dac_cmd_pkg::S_CMD, dac_cmd_pkg::S_FAST_HI: begin
          s_d.hi_cfg = byte_i[7:4];
          s_d.hi_code = byte_i[`D_CODE_HI:`D_CODE_LO];
          if (s_q.st == dac_cmd_pkg::S_FAST_HI) begin
            s_d.st = dac_cmd_pkg::S_FAST_LO;
          end else if (byte_i[`FAST_HI:`FAST_LO] == `CT_FAST) begin
            s_d.chan = 2'h0; // see RULE1
            s_d.st = dac_cmd_pkg::S_FAST_LO; // see RULE15
          end else begin
            s_d.wfunc = byte_i[`WF_HI:`WF_LO]; // see RULE15
            s_d.chan = byte_i[`CS_HI:`CS_LO];
            s_d.update_inhibit_bit_cmd = byte_i[`UPDATE_INHIBIT_BIT_POS];
            s_d.pend = 4'h0;
            unique case (ct)
              `CT_MULTI: begin
                if (byte_i[`WF_HI:`WF_LO] == `WF_MULTI ||
                    byte_i[`WF_HI:`WF_LO] == `WF_SEQ ||
                    byte_i[`WF_HI:`WF_LO] == `WF_SINGLE) begin
                  s_d.st = dac_cmd_pkg::S_CH_HI;
                end else begin
                  s_d.st = dac_cmd_pkg::S_SKIP; // see RULE14
                end
              end
              `CT_ADDR: begin
                // Only the device whose strobe went low is addressed
                s_d.addr_ok = s_q.load_strobe_n_lo &
                  (byte_i[`ADDR_HI:`ADDR_LO] == s_q.addr); // see RULE8
                s_d.st = dac_cmd_pkg::S_ADDR_NEW;
              end
              `CT_VREF: begin
                s_d.in_vref = byte_i[3:0]; // see RULE9
                s_d.st = dac_cmd_pkg::S_SKIP;
              end
              `CT_GAIN: begin
                s_d.in_gain = byte_i[3:0]; // see RULE10
                s_d.st = dac_cmd_pkg::S_SKIP;
              end
              `CT_PD: begin
                s_d.in_pd[0] = byte_i[3:2]; // see RULE11
                s_d.in_pd[1] = byte_i[1:0];
                s_d.st = dac_cmd_pkg::S_CFG_PD2;
              end
              default: s_d.st = dac_cmd_pkg::S_SKIP; // see RULE14
            endcase
          end
        end
        dac_cmd_pkg::S_FAST_LO: begin
          // Write function bits are not looked at here
          s_d.in_code[s_q.chan] = {s_q.hi_code, byte_i}; // see RULE2
          s_d.in_pd[s_q.chan] = s_q.hi_cfg[`FAST_LO-4 +: 2];
          s_d.in_fast[s_q.chan] = 1'b1; // see RULE3
          s_d.chan = s_q.chan + 2'h1;
          s_d.st = (s_q.chan == `LAST_CHAN) ? dac_cmd_pkg::S_SKIP :
                   dac_cmd_pkg::S_FAST_HI;
        end
        dac_cmd_pkg::S_CH_HI: begin
          s_d.hi_cfg = byte_i[7:4];
          s_d.hi_code = byte_i[`D_CODE_HI:`D_CODE_LO];
          s_d.st = dac_cmd_pkg::S_CH_LO;
        end
        dac_cmd_pkg::S_CH_LO: begin
          s_d.in_code[s_q.chan] = {s_q.hi_code, byte_i}; // see RULE4
          s_d.in_vref[s_q.chan] = s_q.hi_cfg[`D_VREF-4];
          s_d.in_pd[s_q.chan] = s_q.hi_cfg[`D_PD_LO-4 +: 2];
          s_d.in_gain[s_q.chan] = s_q.hi_cfg[`D_GAIN-4];
          s_d.in_update_inhibit_bit[s_q.chan] = s_q.update_inhibit_bit_cmd;
          s_d.in_fast[s_q.chan] = 1'b0;
          unique case (s_q.wfunc)
            `WF_SEQ: begin
              s_d.pend = s_q.pend | (4'h1 << s_q.chan); // see RULE6
              s_d.chan = s_q.chan + 2'h1; // see RULE5
              s_d.st = dac_cmd_pkg::S_CH_HI;
              if (s_q.chan == `LAST_CHAN) begin
                s_d.prog_start = 1'b1; // see RULE13
                s_d.st = dac_cmd_pkg::S_SKIP;
              end
            end
            `WF_SINGLE: begin
              s_d.pend = 4'h1 << s_q.chan; // see RULE7
              s_d.prog_start = 1'b1;
              s_d.st = dac_cmd_pkg::S_SKIP;
            end
            default: s_d.st = dac_cmd_pkg::S_CMD; // see RULE4
          endcase
        end
        dac_cmd_pkg::S_CFG_PD2: begin
          s_d.in_pd[2] = byte_i[7:6];
          s_d.in_pd[3] = byte_i[5:4];
          s_d.st = dac_cmd_pkg::S_SKIP;
        end
        dac_cmd_pkg::S_ADDR_NEW: begin
          s_d.new_addr = byte_i[`ADDR_HI:`ADDR_LO];
          s_d.addr_ok = s_q.addr_ok & s_q.load_strobe_n_lo;
          s_d.st = dac_cmd_pkg::S_ADDR_CONF;
        end
        dac_cmd_pkg::S_ADDR_CONF: begin
          s_d.addr_ok = s_q.addr_ok & s_q.load_strobe_n_lo &
            (byte_i[`ADDR_HI:`ADDR_LO] == s_q.new_addr);
          s_d.st = dac_cmd_pkg::S_SKIP;
        end
        default: s_d.st = dac_cmd_pkg::S_SKIP;
      endcase
    end
    // Address takes effect only after the stop condition
    if (stop_i && s_q.addr_ok && s_q.st == dac_cmd_pkg::S_SKIP) begin
      s_d.addr = s_q.new_addr; // see RULE8
      s_d.nvm_addr = s_q.new_addr;
      s_d.addr_ok = 1'b0;
      s_d.prog_start = 1'b1; // see RULE13
    end
    // ----------------------------------------------------------------
    // Deferred nonvolatile copy, done all at once
    // ----------------------------------------------------------------
    if (s_q.prog_start) begin
      for (int c = 0; c < 4; c++) begin
        if (s_q.pend[c]) begin
          s_d.nvm[c] = nvm_word(s_q, 2'(c)); // see RULE6
        end
      end
      s_d.pend = 4'h0;
    end
    // ----------------------------------------------------------------
    // Output update per channel
    // ----------------------------------------------------------------
    for (int c = 0; c < 4; c++) begin
      // Fast-written channels wait for the strobe alone
      if (s_q.load_strobe_n_lo || (!s_q.in_update_inhibit_bit[c] && !s_q.in_fast[c])) begin
        s_d.out_code[c] = s_q.in_code[c]; // see RULE3 see RULE12
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.st <= dac_cmd_pkg::S_CMD;
      s_q.addr <= `RST_ADDR;
      s_q.nvm_addr <= `RST_ADDR;
      s_q.in_update_inhibit_bit <= `RST_INHIBIT;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_code_o = s_q.in_code;
  assign in_vref_o = s_q.in_vref;
  assign in_gain_o = s_q.in_gain;
  assign in_pd_o = s_q.in_pd;
  assign update_inhibit_bit_o = s_q.in_update_inhibit_bit;
  assign out_code_o = s_q.out_code;
  assign nvm_o = s_q.nvm;
  assign bus_addr_o = s_q.addr;
  assign nvm_addr_o = s_q.nvm_addr;
  assign nvm_ready_flag_o = s_q.ready;

endmodule : quad_dac_write_command_decoder
`default_nettype wire

//--- tb/quad_dac_write_command_decoder_assertions.sv
// Port-level assertions for the write command decoder
`timescale 1ns/1ps
`default_nettype none
module dac_cmd_checker #(
  parameter int NVM_PROG_CYCLES = 20
) (
  // Clock, reset and received stream
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic stop_i,
  input wire logic byte_ack_i,
  input wire logic load_strobe_n_i,
  // Registers and status
  input wire dac_cmd_pkg::code_arr_t in_code_o,
  input wire dac_cmd_pkg::pd_arr_t in_pd_o,
  input wire logic [3:0] update_inhibit_bit_o,
  input wire dac_cmd_pkg::code_arr_t out_code_o,
  input wire dac_cmd_pkg::nvm_arr_t nvm_o,
  input wire logic [2:0] bus_addr_o,
  input wire logic nvm_ready_flag_o
);
  logic [21:0] busy_q;
  logic [3:0] low_q;
  // Strobe age saturates so a long high spell cannot wrap
  always_ff @(posedge mclk_i) begin
    busy_q <= (rst_i || nvm_ready_flag_o) ? '0 : busy_q + 22'h1;
    low_q <= (rst_i || !load_strobe_n_i) ? '0 :
      ((low_q == 4'hF) ? low_q : low_q + 4'h1);
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_busy_bounded: assert property (busy_q <= NVM_PROG_CYCLES + 2)
    else $error("busy period too long");
  a_busy_min_len: assert property (!$past(rst_i) &&
    $fell(nvm_ready_flag_o) |-> !nvm_ready_flag_o [*8])
    else $error("busy period too short");
  a_nvm_when_busy: assert property (!$past(rst_i) &&
    !$stable(nvm_o) |-> !nvm_ready_flag_o)
    else $error("nvm changed while ready");
  a_addr_on_stop: assert property (!$past(rst_i) &&
    !$stable(bus_addr_o) |-> $past(stop_i) || $past(stop_i, 2))
    else $error("address changed without stop");
  a_busy_no_write: assert property (!nvm_ready_flag_o |=>
    $stable(in_code_o) && $stable(in_pd_o))
    else $error("register written while busy");
  a_regs_after_ack: assert property (!$past(rst_i) &&
    !$stable({in_code_o, in_pd_o}) |-> $past(byte_ack_i))
    else $error("register changed without ack");
  a_out_gated: assert property (!$past(rst_i) &&
    !$stable(out_code_o) |->
    low_q < 4'h8 || $past(update_inhibit_bit_o) != 4'hF)
    else $error("output moved while gated");
  a_ready_after_rst: assert property ($fell(rst_i) |->
    ##[0:2] nvm_ready_flag_o)
    else $error("ready late after reset");
endmodule : dac_cmd_checker
bind quad_dac_write_command_decoder dac_cmd_checker #(
  .NVM_PROG_CYCLES(NVM_PROG_CYCLES)
) chk (.mclk_i, .rst_i, .stop_i, .byte_ack_i, .load_strobe_n_i, .in_code_o,
  .in_pd_o, .update_inhibit_bit_o, .out_code_o, .nvm_o, .bus_addr_o,
  .nvm_ready_flag_o);
`default_nettype wire

//--- tb/bus_master_model.sv
// Bus master model handing received bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  // Clock and status
  input wire logic mclk_i,
  input wire logic nvm_ready_flag_i,
  // Byte stream
  output logic start_o,
  output logic stop_o,
  output logic ack_o,
  output logic [7:0] byte_o
);
  initial begin
    start_o = 1'h0;
    stop_o = 1'h0;
    ack_o = 1'h0;
    byte_o = 8'hA5;
  end
  // Bytes go back to back, as fast as the slave may take them
  task automatic xfer(input logic [7:0] b[$], output bit hung);
    int n;
    n = 0;
    while (!nvm_ready_flag_i && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    hung = (n == 100);
    start_o = 1'h1;
    @(negedge mclk_i);
    start_o = 1'h0;
    foreach (b[i]) begin
      byte_o = b[i];
      ack_o = 1'h1;
      @(negedge mclk_i);
    end
    ack_o = 1'h0;
    byte_o = ~byte_o;
    stop_o = 1'h1;
    @(negedge mclk_i);
    stop_o = 1'h0;
  endtask : xfer
endmodule : bus_master_model
`default_nettype wire

//--- tb/test_quad_dac_write_command_decoder.sv
// Self-checking bench for the write command decoder
`timescale 1ns/1ps
`default_nettype none
module test_quad_dac_write_command_decoder;
  logic mclk_i, rst_i, start_i, stop_i, byte_ack_i, load_strobe_n_i;
  logic [7:0] byte_i;
  dac_cmd_pkg::code_arr_t in_code, out_code;
  dac_cmd_pkg::pd_arr_t in_pd;
  dac_cmd_pkg::nvm_arr_t nvm;
  logic [3:0] vref, gain, inh;
  logic [2:0] addr, naddr;
  logic rdy;
  int fails = 0;
  int compares = 0;
  bit hung;
  // Short programming time keeps the run brief
  quad_dac_write_command_decoder #(.NVM_PROG_CYCLES(22'h14)) DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .start_i(start_i), .stop_i(stop_i),
    .byte_ack_i(byte_ack_i), .byte_i(byte_i),
    .load_strobe_n_i(load_strobe_n_i), .in_code_o(in_code),
    .in_vref_o(vref), .in_gain_o(gain), .in_pd_o(in_pd),
    .update_inhibit_bit_o(inh), .out_code_o(out_code), .nvm_o(nvm),
    .bus_addr_o(addr), .nvm_addr_o(naddr), .nvm_ready_flag_o(rdy));
  bus_master_model master (.mclk_i(mclk_i), .nvm_ready_flag_i(rdy),
    .start_o(start_i), .stop_o(stop_i), .ack_o(byte_ack_i),
    .byte_o(byte_i));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("Compares %0d, fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic run(input logic [7:0] b[$]);
    master.xfer(b, hung);
    if (hung) begin
      fails++;
      give_verdict();
    end
    repeat (3) @(negedge mclk_i);
  endtask : run
  task automatic wait_ready;
    int n;
    for (n = 0; n < 100 && rdy !== 1'h1; n++) @(negedge mclk_i);
    if (n == 100) begin
      fails++;
      give_verdict();
    end
  endtask : wait_ready
  initial begin
    mclk_i = 1'h0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    rst_i = 1'h1;
    load_strobe_n_i = 1'h1;
    repeat (12) @(negedge mclk_i);
    rst_i = 1'h0;
    repeat (2) @(negedge mclk_i);
    check({inh, rdy, addr}, 8'hF8);
    // Channel B alone, inhibit clear so it reaches the output
    run({8'h42, 8'h9A, 8'h5C});
    check(in_code[1], 12'hA5C);
    check({vref[1], gain[1], inh[1]}, 3'h6);
    check(out_code[1], 12'hA5C);
    run({8'h01, 8'h11, 8'h02, 8'h22, 8'h03, 8'h33, 8'h04, 8'h44});
    check(in_code, 48'h444333222111);
    check(out_code[1], 12'hA5C);
    check(nvm, '0);
    load_strobe_n_i = 1'h0;
    repeat (8) @(negedge mclk_i);
    check(out_code, 48'h444333222111);
    load_strobe_n_i = 1'h1;
    run({8'h5D, 8'h83, 8'h21});
    check(nvm[2], 16'h8321);
    check({rdy, out_code[2]}, 13'h333);
    wait_ready();
    run({8'h54, 8'h0A, 8'hBC, 8'h1D, 8'hEF});
    check(in_code[3:2], 24'hDEFABC);
    check(nvm, 64'h1DEF0ABC00000000);
    check(rdy, 1'h0);
    wait_ready();
    // Config bits ride in the low nibble of the command byte; power-down bits for C and D come in the next byte
    run({8'h99, 8'h09});
    check(vref, 4'h9);
    run({8'hD6, 8'h06});
    check(gain, 4'h6);
    run({8'hAA, 8'hA0, 8'h0A});
    check(in_pd, 8'hAA);
    run({8'hE0, 8'h0F, 8'hFF});
    run({8'h48, 8'hFF, 8'hFF});
    check({vref, in_code}, 52'h9DEFABC222111);
    load_strobe_n_i = 1'h0;
    repeat (4) @(negedge mclk_i);
    run({8'h60, 8'h14, 8'h14});
    load_strobe_n_i = 1'h1;
    check({addr, naddr}, 6'h2D);
    wait_ready();
    give_verdict();
  end
endmodule : test_quad_dac_write_command_decoder
`default_nettype wire
